// ==== common/pcc_consts.vh ====
// Constants for the pulse counter pull-up and threshold configuration block.
// Assumes inclusion by the design files only; holds definitions alone.
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// Register addresses on the special function register port.
`define PCC_ADDR_PULLUP 8'hd7
`define PCC_ADDR_THRESH 8'he4

// Reset values.
`define PCC_RST_PULLUP 8'h44
`define PCC_RST_THRESH 8'h01

// Pull-up configuration field positions.
`define PCC_PU_CAL_START 7
`define PCC_PU_CAL_OUTCOME 6
`define PCC_PU_CAL_SEL 5
`define PCC_PU_STR_HI 4
`define PCC_PU_STR_LO 2

// Threshold configuration field positions.
`define PCC_TH_HI_MSB 7
`define PCC_TH_HI_LSB 6
`define PCC_TH_LO_MSB 5
`define PCC_TH_LO_LSB 4
`define PCC_TH_GROUND 3
`define PCC_TH_PULLUP 2
`define PCC_TH_READ_OK 0

// Writable bits of the threshold register; bit 1 is reserved.
`define PCC_TH_WMASK 8'hfc

// Pattern loaded into the low five bits when calibration fails.
`define PCC_CAL_FAIL 5'h11

// Strength code that disables the pull-up.
`define PCC_STR_OFF 3'h0

// Settle time per calibration trial step.
`define PCC_CAL_STEP_NS 1000
`define PCC_CLK_NS 100
`define PCC_CAL_STEP_CYC ((`PCC_CAL_STEP_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

`endif

// ==== hw/pcc_cfg.v ====
// Pull-up, threshold and read-valid configuration for a two-input pulse counter.
// Assumes an 8-bit register port on the system clock and comparator outputs from the pins.
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_cfg #(
	parameter DUTY_PERIOD = 64
) (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	input wire i_rt_rd,
	input wire i_rt_changed,
	input wire i_rt_lo_rd,
	input wire [15:0] i_ctr_mid_hi,
	input wire [3:0] i_rate_eighths,
	input wire i_cmp_a,
	input wire i_cmp_b,
	output reg [7:0] o_rdata,
	output reg [15:0] o_ctr_latch,
	output reg [2:0] o_pullup_strength,
	output reg o_pullup_on,
	output reg o_force_ground,
	output reg [1:0] o_high_threshold_sel,
	output reg [1:0] o_low_threshold_sel,
	output reg o_cal_input_select,
	output reg o_cal_busy
);
	localparam ST_IDLE = 2'h0;
	localparam ST_TRY = 2'h1;
	localparam ST_WAIT = 2'h2;
	// Settle count is worked out as an integer, then cut to the wait counter width.
	localparam integer STEP_CYC_N = `PCC_CAL_STEP_CYC;
	localparam [3:0] STEP_CYC = STEP_CYC_N[3:0];
	localparam [7:0] TH_WMASK = `PCC_TH_WMASK;

	reg [7:0] pu_q;
	reg [7:0] th_q;
	reg [1:0] st_q;
	reg [3:0] wait_q;
	reg [2:0] try_q;
	reg cmp_a_m_q;
	reg cmp_a_q;
	reg cmp_b_m_q;
	reg cmp_b_q;
	wire duty_on;
	wire cal_in;
	wire wr_pu;
	wire wr_th;

	assign wr_pu = i_wr && (i_addr == `PCC_ADDR_PULLUP);
	assign wr_th = i_wr && (i_addr == `PCC_ADDR_THRESH);
	assign cal_in = pu_q[`PCC_PU_CAL_SEL] ? cmp_b_q : cmp_a_q;

	// Next trial strength; skips the unused 110 code.
	function [2:0] next_str;
		input [2:0] s;
		begin
			next_str = (s == 3'h5) ? 3'h7 : s + 3'h1;
		end
	endfunction

	pcc_duty_gen #(
		.PERIOD(DUTY_PERIOD)
	) u_duty (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_duty_sel(pu_q[1:0]),
		.i_rate_eighths(i_rate_eighths),
		.o_on(duty_on)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Comparator pins come from the pad domain, so each passes two flops.
	always @(posedge i_clk) begin
		if (i_rst) begin
			cmp_a_m_q <= 1'b0;
			cmp_a_q <= 1'b0;
			cmp_b_m_q <= 1'b0;
			cmp_b_q <= 1'b0;
		end else begin
			cmp_a_m_q <= i_cmp_a;
			cmp_a_q <= cmp_a_m_q;
			cmp_b_m_q <= i_cmp_b;
			cmp_b_q <= cmp_b_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pull-up register and calibration search. Writes are ignored while busy so
	// firmware cannot disturb the strength under trial.
	always @(posedge i_clk) begin
		if (i_rst) begin
			pu_q <= `PCC_RST_PULLUP;
			st_q <= ST_IDLE;
			wait_q <= 4'h0;
			try_q <= 3'h0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (wr_pu) begin
					pu_q[5:0] <= i_wdata[5:0];
					if (i_wdata[`PCC_PU_CAL_START]) begin
						pu_q[`PCC_PU_CAL_START] <= 1'b1;
						try_q <= 3'h1;
						wait_q <= STEP_CYC;
						st_q <= ST_TRY;
					end
				end
			end
			ST_TRY: begin
				// Hold the trial strength long enough for the input to settle.
				if (wait_q != 4'h0) begin
					wait_q <= wait_q - 4'h1;
				end else begin
					st_q <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cal_in) begin
					pu_q[`PCC_PU_CAL_OUTCOME] <= 1'b1;
					pu_q[4:0] <= {try_q, pu_q[1:0]};
					pu_q[`PCC_PU_CAL_START] <= 1'b0;
					st_q <= ST_IDLE;
				end else if (try_q == 3'h7) begin
					// A closed switch keeps the input low at every strength.
					pu_q[`PCC_PU_CAL_OUTCOME] <= 1'b0;
					pu_q[4:0] <= `PCC_CAL_FAIL;
					pu_q[`PCC_PU_CAL_START] <= 1'b0;
					st_q <= ST_IDLE;
				end else begin
					try_q <= next_str(try_q);
					wait_q <= STEP_CYC;
					st_q <= ST_TRY;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Threshold register with the read-valid flag. A failed real-time read
	// clears the flag; reading the flag restores it, but a failure in the same
	// cycle wins so it is never lost.
	always @(posedge i_clk) begin
		if (i_rst) begin
			th_q <= `PCC_RST_THRESH;
		end else begin
			if (wr_th) begin
				th_q[7:2] <= i_wdata[7:2] & TH_WMASK[7:2];
			end
			if (i_rt_rd && i_rt_changed) begin
				th_q[`PCC_TH_READ_OK] <= 1'b0;
			end else if (i_rt_rd) begin
				th_q[`PCC_TH_READ_OK] <= 1'b1;
			end else if (i_rd && i_addr == `PCC_ADDR_THRESH) begin
				th_q[`PCC_TH_READ_OK] <= 1'b1;
			end
			th_q[1] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter upper bytes are frozen on the low-byte read for a coherent pair.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_ctr_latch <= 16'h0000;
		end else if (i_rt_lo_rd) begin
			o_ctr_latch <= i_ctr_mid_hi;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, registered; unmapped addresses return zero.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_addr == `PCC_ADDR_PULLUP) begin
			o_rdata <= pu_q;
		end else if (i_addr == `PCC_ADDR_THRESH) begin
			o_rdata <= th_q;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pad controls. Ground overrides any pull-up; during calibration the trial
	// strength is driven continuously.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_pullup_strength <= `PCC_STR_OFF;
			o_pullup_on <= 1'b0;
			o_force_ground <= 1'b0;
			o_high_threshold_sel <= 2'h0;
			o_low_threshold_sel <= 2'h0;
			o_cal_input_select <= 1'b0;
			o_cal_busy <= 1'b0;
		end else begin
			o_force_ground <= th_q[`PCC_TH_GROUND];
			o_cal_busy <= (st_q != ST_IDLE);
			o_cal_input_select <= pu_q[`PCC_PU_CAL_SEL];
			o_high_threshold_sel <= th_q[`PCC_TH_HI_MSB:`PCC_TH_HI_LSB];
			o_low_threshold_sel <= th_q[`PCC_TH_LO_MSB:`PCC_TH_LO_LSB];
			if (st_q != ST_IDLE) begin
				o_pullup_strength <= try_q;
				o_pullup_on <= ~th_q[`PCC_TH_GROUND];
			end else begin
				o_pullup_strength <= pu_q[`PCC_PU_STR_HI:`PCC_PU_STR_LO];
				if (th_q[`PCC_TH_GROUND]) begin
					o_pullup_on <= 1'b0;
				end else if (th_q[`PCC_TH_PULLUP]) begin
					o_pullup_on <= 1'b1;
				end else begin
					o_pullup_on <= duty_on;
				end
			end
		end
	end
endmodule

// ==== hw/pcc_duty_gen.v ====
// Pull-up duty-cycle gate: applies the pull-up for a fraction of each sample period.
// Assumes a sample-rate fraction in eighths; the sample period comes from its own free-running counter.
`timescale 1ns/1ps
module pcc_duty_gen #(
	parameter PERIOD = 64
) (
	input wire i_clk,
	input wire i_rst,
	input wire [1:0] i_duty_sel,
	input wire [3:0] i_rate_eighths,
	output reg o_on
);
	reg [6:0] cnt_q;
	reg [13:0] on_len;

	// Pull-up fraction in eighths is 2, 3, 4 or 6, multiplied by the sample-rate fraction.
	always @* begin
		case (i_duty_sel)
		2'h0: on_len = 14'h2 * i_rate_eighths;
		2'h1: on_len = 14'h3 * i_rate_eighths;
		2'h2: on_len = 14'h4 * i_rate_eighths;
		default: on_len = 14'h6 * i_rate_eighths;
		endcase
	end

	// Free-running period counter; output high while count is under the product share.
	always @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= 7'h00;
			o_on <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 7'h00 : cnt_q + 7'h01;
			o_on <= ({7'h00, cnt_q} * 14'h40) < (on_len * PERIOD);
		end
	end
endmodule

// ==== tb/pcc_cfg_chk_sva.sv ====
// Assertions on the ports of the pull-up and threshold configuration block.
// Assumes it is bound into pcc_cfg and sees only that module's ports.
`timescale 1ns/1ps
module pcc_cfg_chk (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	input wire i_rt_rd,
	input wire i_rt_changed,
	input wire i_rt_lo_rd,
	input wire [15:0] i_ctr_mid_hi,
	input wire [7:0] o_rdata,
	input wire [15:0] o_ctr_latch,
	input wire [2:0] o_pullup_strength,
	input wire o_pullup_on,
	input wire o_force_ground,
	input wire [1:0] o_high_threshold_sel,
	input wire [1:0] o_low_threshold_sel,
	input wire o_cal_input_select,
	input wire o_cal_busy
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	////////////////
	// A failed real-time read, or a flag read, then a look at the flag register.
	sequence s_bad_rt;
		i_rt_rd && i_rt_changed ##1 i_addr == 8'he4 && !i_rt_rd;
	endsequence
	sequence s_flag_rd;
		i_rd && i_addr == 8'he4 && !i_rt_rd ##1 i_addr == 8'he4 && !i_rt_rd;
	endsequence
	property p_bad_rt;
		s_bad_rt |=> !o_rdata[0];
	endproperty
	a_bad_rt: assert property (p_bad_rt) else $error("flag kept");
	property p_flag_rd;
		s_flag_rd |=> o_rdata[0];
	endproperty
	a_flag_rd: assert property (p_flag_rd) else $error("flag low");
	// Outputs follow a register write two cycles on; local copy of the data.
	property p_thr;
		logic [7:0] d;
		(i_wr && i_addr == 8'he4, d = i_wdata) |-> ##2
			o_force_ground == d[3] && {o_high_threshold_sel, o_low_threshold_sel} == d[7:4];
	endproperty
	a_thr: assert property (p_thr) else $error("thr out");
	property p_pu;
		i_wr && i_addr == 8'he4 && i_wdata[3:2] == 2'b01 |-> ##2 o_pullup_on;
	endproperty
	a_pu: assert property (p_pu) else $error("pull-up off");
	property p_gnd;
		o_force_ground |-> !o_pullup_on;
	endproperty
	a_gnd: assert property (p_gnd) else $error("pull-up on");
	property p_cfg;
		logic [7:0] d;
		(i_wr && i_addr == 8'hd7 && !i_wdata[7] && !o_cal_busy, d = i_wdata) |-> ##2
			o_cal_input_select == d[5] && o_pullup_strength == d[4:2];
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg out");
	// Calibration must start within two cycles and end within a bounded search.
	property p_cal;
		i_wr && i_addr == 8'hd7 && i_wdata[7] && !o_cal_busy |->
			##[1:2] o_cal_busy ##[1:150] !o_cal_busy;
	endproperty
	a_cal: assert property (p_cal) else $error("cal");
	property p_unmap;
		i_addr != 8'hd7 && i_addr != 8'he4 |=> o_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_latch;
		i_rt_lo_rd |=> o_ctr_latch == $past(i_ctr_mid_hi);
	endproperty
	a_latch: assert property (p_latch) else $error("latch");
endmodule
bind pcc_cfg pcc_cfg_chk u_chk (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .i_rt_rd,
	.i_rt_changed, .i_rt_lo_rd, .i_ctr_mid_hi, .o_rdata, .o_ctr_latch, .o_pullup_strength,
	.o_pullup_on, .o_force_ground, .o_high_threshold_sel, .o_low_threshold_sel,
	.o_cal_input_select, .o_cal_busy);

// ==== tb/pcc_reed.sv ====
// Two reed switch inputs as seen through the pad comparators.
// Assumes pad capacitance holds the level between duty pulses.
`timescale 1ns/1ps
module pcc_reed #(
	parameter MIN_STR = 3
) (
	input wire [2:0] i_strength,
	input wire i_ground,
	input wire i_closed_a,
	input wire i_closed_b,
	output wire o_cmp_a,
	output wire o_cmp_b
);
	////////////////
	// A closed switch or forced ground holds a pad low; a weak pull-up never lifts it.
	wire lift = !i_ground && i_strength >= MIN_STR;
	assign o_cmp_a = lift && !i_closed_a;
	assign o_cmp_b = lift && !i_closed_b;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the pull-up and threshold configuration block.
// Assumes the reed model on the comparator inputs and the checker bound in.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	reg i_clk = 0;
	reg i_rst = 1;
	reg i_wr = 0, i_rd = 0, i_rt_rd = 0, i_rt_changed = 0, i_rt_lo_rd = 0, closed_b = 0;
	reg [7:0] i_addr = 0, i_wdata = 0, w;
	reg [15:0] i_ctr_mid_hi = 0;
	reg [3:0] i_rate_eighths = 8;
	reg [31:0] seed = 91688;
	integer fail_count = 0, tests_run = 0, cyc = 0, m_th = 1, k, i;
	wire cmp_a, cmp_b, o_pullup_on, o_force_ground, o_cal_input_select, o_cal_busy;
	wire [1:0] o_high_threshold_sel, o_low_threshold_sel;
	wire [2:0] o_pullup_strength;
	wire [7:0] o_rdata;
	wire [15:0] o_ctr_latch;
	pcc_cfg u_pcc_cfg (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .i_wdata, .i_rt_rd,
		.i_rt_changed, .i_rt_lo_rd, .i_ctr_mid_hi, .i_rate_eighths, .i_cmp_a(cmp_a),
		.i_cmp_b(cmp_b), .o_rdata, .o_ctr_latch, .o_pullup_strength, .o_pullup_on,
		.o_force_ground, .o_high_threshold_sel, .o_low_threshold_sel, .o_cal_input_select,
		.o_cal_busy);
	pcc_reed u_pcc_reed (.i_strength(o_pullup_strength), .i_ground(o_force_ground),
		.i_closed_a(1'b0), .i_closed_b(closed_b), .o_cmp_a(cmp_a), .o_cmp_b(cmp_b));
	////////////////
	// Clock, and a cycle ceiling so a hung calibration still ends the run.
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			fail_count = fail_count + 1;
			end_sim;
		end
	end
	function [31:0] rnd(input [31:0] x);
		rnd = x ^ (x << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
	endfunction
	// Register port cycles: strobe for one edge, data read once it has landed.
	task wr(input [7:0] a, input [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 `CHK(o_rdata, e)
	endtask
	// A counter low-byte read, clean or disturbed, with fresh live upper bytes.
	task rt(input c);
		seed = rnd(seed);
		@(posedge i_clk);
		i_addr <= 8'he4;
		{i_rt_rd, i_rt_lo_rd, i_rt_changed} <= {2'b11, c};
		i_ctr_mid_hi <= seed[15:0];
		@(posedge i_clk);
		{i_rt_rd, i_rt_lo_rd} <= 2'b00;
		m_th = c ? m_th & 8'hfe : m_th | 1;
		#1 `CHK(o_ctr_latch, seed[15:0])
	endtask
	task end_sim;
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence; the model is m_th for the threshold register.
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'hd7, 8'h44);
		rd(8'he4, 8'h01);
		rd(8'h55, 8'h00);
		for (k = 0; k < 8; k = k + 1) begin
			seed = rnd(seed);
			w = {k[1:0], ~k[1:0], seed[3:0]};
			i_rate_eighths <= {1'b0, seed[6:4]};
			wr(8'he4, w);
			m_th = (w & 8'hfc) | (m_th & 1);
			rd(8'he4, m_th[7:0]);
			m_th = m_th | 1;
			`CHK({o_high_threshold_sel, o_low_threshold_sel, o_force_ground}, w[7:3])
			if (w[3]) `CHK(o_pullup_on, 1'b0)
			else if (w[2]) `CHK(o_pullup_on, 1'b1)
		end
		for (k = 1; k >= 0; k = k - 1) begin
			rt(k[0]);
			rd(8'he4, m_th[7:0]);
			m_th = m_th | 1;
			rd(8'he4, m_th[7:0]);
		end
		wr(8'he4, 8'h00);
		for (k = 0; k < 2; k = k + 1) begin
			closed_b <= k[0];
			wr(8'hd7, {2'b10, k[0], 5'h02});
			i = 0;
			// Busy is looked at just after each edge, once it has settled.
			repeat (3) @(posedge i_clk);
			#1;
			while (o_cal_busy !== 1'b0 && i < 200) begin
				@(posedge i_clk);
				#1 i = i + 1;
			end
			`CHK(o_cal_input_select, k[0])
			rd(8'hd7, k ? 8'h31 : 8'h4e);
		end
		wr(8'hd7, 8'h4c);
		rd(8'hd7, 8'h0c);
		// High cycles in one 64-cycle sample period: eighths of the duty code times rate eighths.
		for (k = 0; k < 4; k = k + 1) begin
			seed = rnd(seed);
			@(posedge i_clk);
			i_rate_eighths <= {1'b0, seed[6:4]};
			wr(8'hd7, {6'h03, k[1:0]});
			repeat (4) @(posedge i_clk);
			i = 0;
			repeat (64) begin
				@(posedge i_clk);
				#1 i = i + o_pullup_on;
			end
			`CHK(i, (k == 3 ? 6 : k + 2) * seed[6:4])
		end
		end_sim;
	end
endmodule
